// ### arb_pkg.sv
// Shared constants, types and code helper for the external event arbiter.
package arb_pkg;
  localparam int N_IRQ   = 6;
  localparam int N_IFC   = 5;
  localparam int N_VEC   = 8;
  localparam int N_SEL   = 32;
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int CODE_W  = 8;
  localparam int VEC_W   = 3;

  // Vector slots: halt, power fail, then the six device requests.
  localparam logic [VEC_W-1:0] VEC_HALT = 3'h0;
  localparam logic [VEC_W-1:0] VEC_PWR  = 3'h1;
  localparam logic [VEC_W-1:0] VEC_IRQ0 = 3'h2;
  localparam int               POS_HALT = 0;
  localparam int               POS_PWR  = 1;
  localparam int               POS_IRQ0 = 2;

  // Code layout: high field, vector number, low field.
  localparam logic [1:0]        CODE_HI  = 2'h0;
  localparam logic [2:0]        CODE_LO  = 3'h5;
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] BUS_RST  = 8'h00;

  typedef enum logic {ARB_IDLE, ARB_HOLD} arb_state_t;

  function automatic logic [CODE_W-1:0] vec_code(logic [VEC_W-1:0] v);
    return {CODE_HI, v, CODE_LO};
  endfunction : vec_code
endpackage : arb_pkg

// ### dsel_if.sv
// Carrier between the arbiter top and its device-select decoder.
`timescale 1ns/1ps
`default_nettype none
interface dsel_if;
  import arb_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              gate;
  logic [N_SEL-1:0]  sel_n;
  modport decoder (input addr, input gate, output sel_n);
  modport user    (output addr, output gate, input sel_n);
endinterface : dsel_if
`default_nettype wire

// ### select_decoder.sv
// Gated 5-to-32 device-select decoder with active-low outputs.
`timescale 1ns/1ps
`default_nettype none
module select_decoder
  import arb_pkg::*;
(
  // Decoder side of the carrier
  dsel_if.decoder ds
);
  logic [N_SEL-1:0] hot;

  always_comb begin
    hot = '0;
    if (ds.gate) begin
      hot[ds.addr] = 1'b1;
    end
  end

  // Outputs are low-true; the inverter stage in the top restores them.
  assign ds.sel_n = ~hot;
endmodule : select_decoder
`default_nettype wire

// ### external_event_arbiter.sv
// External event arbiter with select decoder and parallel input channels.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Watch six device requests, power fail and halt together.
// - Rank pending requests and present an encoded winner to the processor.
// - Halt outranks power fail and every device request.
// - Power fail, ac or dc, outranks every device request.
// - Device request priority is fixed by its input position.
// - Derive a line-frequency sync signal from the ac reference.
// - Decode a five-bit address to one of five inputs or 27 other select lines.
// - Decode 5-to-32 only while gated; each output selects its own slot.
// - A channel drives its word onto the input bus only when selected.
// - Channels give device handshake signals and raise a request on data.
// - At most five input channels, each with one word and one request.
// - Select lines and channel requests are inverted before use.
// - Rising data-ready sets the flag; the select transfer clears it.
// - A recognised request yields an 8-bit code naming one of eight vectors.
module external_event_arbiter
  import arb_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  // External events
  input  wire logic                          halt_req,
  input  wire logic                          pwr_fail_ac,
  input  wire logic                          pwr_fail_dc,
  input  wire logic                          ac_ref,
  input  wire logic                          ext_irq_n,
  // Processor side
  input  wire logic [ADDR_W-1:0]             dev_addr,
  input  wire logic                          sel_gate,
  input  wire logic                          int_ack,
  output logic                               int_req,
  output logic [CODE_W-1:0]                  int_code,
  output logic                               ac_sync,
  output logic [N_SEL-1:0]                   dev_sel,
  output logic [DATA_W-1:0]                  in_bus,
  output logic                               in_bus_oe,
  // Input device side
  input  wire logic [N_IFC-1:0][DATA_W-1:0]  dev_data,
  input  wire logic [N_IFC-1:0]              dev_ready,
  output logic [N_IFC-1:0]                   dev_taken,
  output logic [N_IFC-1:0]                   dev_busy
);
  dsel_if ds ();

  logic [N_IFC-1:0]  take;
  logic [N_IFC-1:0]  rise;
  logic [N_IFC-1:0]  ifc_irq_n;
  logic [N_IRQ-1:0]  irq;
  logic              pwr_fail;
  logic [N_VEC-1:0]  all_req;

  // Decoder and inverter stage.
  assign ds.addr = dev_addr;
  assign ds.gate = sel_gate;

  select_decoder u_dec (
    .ds (ds)
  );

  assign dev_sel = ~ds.sel_n;

  // Input channel i answers to input device address i.
  assign take = dev_sel[N_IFC-1:0];

  // Input channels: request flags, handshake and bus word.
  logic [N_IFC-1:0]  ready_q, ready_d;
  logic [N_IFC-1:0]  flag_q, flag_d;
  logic [N_IFC-1:0]  taken_q, taken_d;
  logic [DATA_W-1:0] bus_q, bus_d;
  logic              oe_q, oe_d;

  assign rise = dev_ready & ~ready_q;

  always_comb begin
    ready_d = dev_ready;
    // A strobe landing in the transfer cycle is kept: the set wins.
    flag_d  = (flag_q & ~take) | rise;
    taken_d = take;
    bus_d   = BUS_RST;
    oe_d    = |take;
    for (int i = 0; i < N_IFC; i++) begin
      if (take[i]) begin
        bus_d = dev_data[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_q <= '0;
      flag_q  <= '0;
      taken_q <= '0;
      bus_q   <= BUS_RST;
      oe_q    <= 1'b0;
    end else if (clk_en) begin
      ready_q <= ready_d;
      flag_q  <= flag_d;
      taken_q <= taken_d;
      bus_q   <= bus_d;
      oe_q    <= oe_d;
    end
  end

  assign dev_busy  = flag_q;
  assign dev_taken = taken_q;
  assign in_bus    = bus_q;
  assign in_bus_oe = oe_q;

  // Channel requests leave low-true and are inverted toward the arbiter.
  assign ifc_irq_n = ~flag_q;
  assign irq       = ~{ext_irq_n, ifc_irq_n};
  assign pwr_fail  = pwr_fail_ac | pwr_fail_dc;
  assign all_req   = {irq, pwr_fail, halt_req};

  // Arbiter: lowest slot wins, so halt beats power fail beats devices.
  arb_state_t        state_q, state_d;
  logic [VEC_W-1:0]  vec_q, vec_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic [VEC_W-1:0]  win;

  always_comb begin
    win = VEC_HALT;
    for (int k = N_VEC-1; k >= 0; k--) begin
      if (all_req[k]) begin
        win = VEC_W'(k);
      end
    end
  end

  always_comb begin
    state_d = state_q;
    vec_d   = vec_q;
    code_d  = code_q;
    case (state_q)
      ARB_IDLE: begin
        if (|all_req) begin
          vec_d   = win;
          code_d  = vec_code(win);
          state_d = ARB_HOLD;
        end
      end
      ARB_HOLD: begin
        // A newly raised higher request waits; the code must not shift.
        if (int_ack || !all_req[vec_q]) begin
          state_d = ARB_IDLE;
        end
      end
      default: state_d = ARB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ARB_IDLE;
      vec_q   <= VEC_HALT;
      code_q  <= CODE_RST;
    end else if (clk_en) begin
      state_q <= state_d;
      vec_q   <= vec_d;
      code_q  <= code_d;
    end
  end

  assign int_req  = (state_q == ARB_HOLD);
  assign int_code = code_q;

  // Line-frequency sync: one pulse per rising edge of the ac reference.
  logic ac_q, ac_d;
  logic sync_q, sync_d;

  always_comb begin
    ac_d   = ac_ref;
    sync_d = ac_ref & ~ac_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ac_q   <= 1'b0;
      sync_q <= 1'b0;
    end else if (clk_en) begin
      ac_q   <= ac_d;
      sync_q <= sync_d;
    end
  end

  assign ac_sync = sync_q;

  // Checks.
  chk_halt_first: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && state_q == ARB_IDLE && halt_req
    |=> int_req && int_code == vec_code(VEC_HALT))
    else $error("halt did not win arbitration");

  chk_pwr_over_irq: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && state_q == ARB_IDLE && !halt_req && pwr_fail
    |=> int_code == vec_code(VEC_PWR))
    else $error("power fail did not beat device requests");

  chk_irq_rank: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && state_q == ARB_IDLE && !all_req[POS_HALT]
    && !all_req[POS_PWR] && all_req[POS_IRQ0]
    |=> int_code == vec_code(VEC_IRQ0))
    else $error("first device request lost to a lower one");

  chk_code_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && int_req && !int_ack && all_req[vec_q]
    |=> int_req && $stable(int_code))
    else $error("held code changed before ack or withdrawal");

  chk_code_drop: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && int_req && int_ack |=> !int_req)
    else $error("request stayed up after acknowledge");

  chk_sel_decode: assert property (
    @(posedge core_clk) disable iff (rst)
    sel_gate ? (dev_sel[dev_addr] && $onehot(dev_sel)) : (dev_sel == '0))
    else $error("select lines do not match gated address");

  chk_flag_set: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && rise != '0 |=> (dev_busy & $past(rise)) == $past(rise))
    else $error("data-ready edge did not set the flag");

  chk_flag_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && (take & ~rise) != '0
    |=> (dev_busy & $past(take & ~rise)) == '0)
    else $error("transfer did not clear the flag");

  chk_bus_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en |=> in_bus_oe == $past(|take)
    && (in_bus_oe || in_bus == BUS_RST))
    else $error("input bus driven without a select");

  chk_ac_sync: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en |=> ac_sync == ($past(ac_ref) && !$past(ac_q)))
    else $error("ac sync pulse wrong");
endmodule : external_event_arbiter
`default_nettype wire

// ### input_device_model.sv
// Input device model that hands one word per channel and waits for take.
`timescale 1ns/1ps
`default_nettype none
module input_device_model
  import arb_pkg::*;
(
  // Clock, reset and scenario control
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [N_IFC-1:0]        go,
  // Device cable
  input  wire logic [N_IFC-1:0]        dev_taken,
  output logic [N_IFC-1:0][DATA_W-1:0] dev_data,
  output logic [N_IFC-1:0]             dev_ready
);
  logic [N_IFC-1:0] arm_q;
  // Data settles a cycle ahead of the strobe; the strobe holds until taken.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arm_q     <= '0;
      dev_ready <= '0;
    end else begin
      arm_q     <= go;
      dev_ready <= (dev_ready & ~dev_taken) | arm_q;
    end
  end
  // A stale word is inverted so a late sample cannot pass by luck.
  for (genvar i = 0; i < N_IFC; i++) begin : g_word
    assign dev_data[i] = (arm_q[i] | dev_ready[i]) ? 8'ha0 + 8'(i)
                                                   : ~(8'ha0 + 8'(i));
  end
endmodule : input_device_model
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the external event arbiter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import arb_pkg::*;
  logic                    core_clk, rst, halt_req, pwr_fail_ac, pwr_fail_dc;
  logic                    ac_ref, ext_irq_n, sel_gate, int_ack, int_req;
  logic                    ac_sync, in_bus_oe, clk_en;
  logic [ADDR_W-1:0]       dev_addr;
  logic [CODE_W-1:0]       int_code;
  logic [DATA_W-1:0]       in_bus;
  logic [N_SEL-1:0]        dev_sel;
  logic [N_IFC-1:0][7:0]   dev_data;
  logic [N_IFC-1:0]        dev_ready, dev_taken, dev_busy, go;
  int                      n_fail, check_count;

  external_event_arbiter dut (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .halt_req(halt_req),
    .pwr_fail_ac(pwr_fail_ac), .pwr_fail_dc(pwr_fail_dc), .ac_ref(ac_ref),
    .ext_irq_n(ext_irq_n), .dev_addr(dev_addr), .sel_gate(sel_gate),
    .int_ack(int_ack), .int_req(int_req), .int_code(int_code),
    .ac_sync(ac_sync), .dev_sel(dev_sel), .in_bus(in_bus),
    .in_bus_oe(in_bus_oe), .dev_data(dev_data), .dev_ready(dev_ready),
    .dev_taken(dev_taken), .dev_busy(dev_busy));
  input_device_model partner (
    .core_clk(core_clk), .rst(rst), .go(go), .dev_taken(dev_taken),
    .dev_data(dev_data), .dev_ready(dev_ready));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] code_of(input int v);
    return 8'h05 | 8'(v << 3);
  endfunction : code_of

  // Bounded wait, since a lost request must not hang the run.
  task automatic wait_req;
    for (int n = 0; n < 20 && int_req !== 1'b1; n++) @(negedge core_clk);
    check(int_req, 1'b1);
  endtask : wait_req

  task automatic ack_and_drop;
    int_ack = 1'b1;
    @(negedge core_clk);
    int_ack = 1'b0;
    check(int_req, 1'b0);
    @(negedge core_clk);
  endtask : ack_and_drop

  task automatic serve(input int i);
    dev_addr = 5'(i);
    sel_gate = 1'b1;
    #1 check(dev_sel, 32'h1 << i);
    @(negedge core_clk);
    sel_gate = 1'b0;
    check(in_bus, 8'ha0 + 8'(i));
    check(in_bus_oe, 1'b1);
    check(dev_taken, 5'h1 << i);
    check(dev_busy[i], 1'b0);
    @(negedge core_clk);
    check(in_bus_oe, 1'b0);
    check(in_bus, 8'h00);
  endtask : serve

  task automatic t_decoder;
    for (int a = 0; a < N_SEL; a++) begin
      dev_addr = 5'(a);
      sel_gate = 1'b1;
      #1 check(dev_sel, 32'h1 << a);
      @(negedge core_clk);
      sel_gate = 1'b0;
      #1 check(dev_sel, 32'h0);
      check(in_bus_oe, 32'(a < N_IFC));
      @(negedge core_clk);
    end
    $display("t_decoder done");
  endtask : t_decoder

  task automatic t_events;
    for (int k = 0; k < 4; k++) begin
      halt_req = (k == 0);
      pwr_fail_ac = (k == 1);
      pwr_fail_dc = (k == 2);
      ext_irq_n = (k != 3);
      @(negedge core_clk);
      wait_req();
      check(int_code, code_of(k == 0 ? 0 : k == 3 ? 7 : 1));
      {halt_req, pwr_fail_ac, pwr_fail_dc, ext_irq_n} = 4'h1;
      ack_and_drop();
    end
    $display("t_events done");
  endtask : t_events

  task automatic t_channels;
    for (int i = 0; i < N_IFC; i++) begin
      go = 5'h1 << i;
      @(negedge core_clk);
      go = '0;
      wait_req();
      check(int_code, code_of(2 + i));
      check(dev_busy, 5'h1 << i);
      serve(i);
    end
    $display("t_channels done");
  endtask : t_channels

  task automatic t_rank;
    ext_irq_n = 1'b0;
    go = 5'h0a;
    @(negedge core_clk);
    go = '0;
    wait_req();
    check(int_code, code_of(7));
    halt_req = 1'b1;
    pwr_fail_dc = 1'b1;
    repeat (4) @(negedge core_clk);
    check(int_code, code_of(7));
    ack_and_drop();
    wait_req();
    check(int_code, code_of(0));
    halt_req = 1'b0;
    ack_and_drop();
    wait_req();
    check(int_code, code_of(1));
    pwr_fail_dc = 1'b0;
    ack_and_drop();
    wait_req();
    check(int_code, code_of(3));
    serve(1);
    wait_req();
    check(int_code, code_of(5));
    serve(3);
    ext_irq_n = 1'b1;
    $display("t_rank done");
  endtask : t_rank

  // Frozen enable must hold off arbitration; a mid-run reset clears the code.
  task automatic t_freeze_reset;
    clk_en = 1'b0;
    halt_req = 1'b1;
    repeat (3) @(negedge core_clk);
    check(int_req, 1'b0);
    clk_en = 1'b1;
    @(negedge core_clk);
    check(int_req, 1'b1);
    check(int_code, code_of(0));
    rst = 1'b1;
    #1 check(int_req, 1'b0);
    check(int_code, 8'h00);
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check(int_req, 1'b1);
    check(int_code, code_of(0));
    halt_req = 1'b0;
    ack_and_drop();
    $display("t_freeze_reset done");
  endtask : t_freeze_reset

  task automatic t_ac;
    ac_ref = 1'b1;
    @(negedge core_clk);
    check(ac_sync, 1'b1);
    @(negedge core_clk);
    check(ac_sync, 1'b0);
    ac_ref = 1'b0;
    $display("t_ac done");
  endtask : t_ac

  initial begin
    {rst, ext_irq_n} = 2'h3;
    {halt_req, pwr_fail_ac, pwr_fail_dc, ac_ref, sel_gate, int_ack} = '0;
    dev_addr = '0;
    go = '0;
    clk_en = 1'b1;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_decoder();
    t_events();
    t_channels();
    t_rank();
    t_freeze_reset();
    t_ac();
    report_and_stop();
  end

  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
